// ---- sra_pkg.sv ----
// shared constants and types for the spi register access block
package sra_pkg;

    // control register addresses, one byte each
    localparam logic [6:0] MODE_AND_SUPPLY_CONTROL = 7'h00;
    localparam logic [6:0] HARDWARE_CONFIG_0       = 7'h01;
    localparam logic [6:0] WATCHDOG_CONTROL        = 7'h02;
    localparam logic [6:0] CAN_TRANSCEIVER_CONTROL = 7'h03;
    localparam logic [6:0] WAKE_CONTROL_0          = 7'h04;
    localparam logic [6:0] WAKE_CONTROL_1          = 7'h05;
    localparam logic [6:0] WAKE_PULL_CONTROL       = 7'h06;
    localparam logic [6:0] CAN_FLASH_CONTROL       = 7'h07;
    localparam logic [6:0] CYCLIC_TIMER_CONTROL    = 7'h08;
    localparam logic [6:0] HARDWARE_CONFIG_1       = 7'h09;
    localparam logic [6:0] HARDWARE_CONFIG_2       = 7'h0A;
    localparam logic [6:0] GENERAL_PIN_CONFIG      = 7'h0B;
    localparam logic [6:0] PWM_DUTY_CONTROL        = 7'h0C;
    localparam logic [6:0] PWM_FREQUENCY_CONTROL   = 7'h0D;
    localparam logic [6:0] HARDWARE_CONFIG_3       = 7'h0E;
    localparam int         CTRL_NUM                = 15;

    // selective wake range and its read-only calibration bytes
    localparam logic [6:0] SWK_BASE       = 7'h20;
    localparam logic [6:0] SWK_TOP        = 7'h3F;
    localparam int         SWK_NUM        = 8;
    localparam logic [6:0] OSC_CAL_H_ADDR = 7'h38;
    localparam logic [6:0] OSC_CAL_L_ADDR = 7'h39;

    // status range
    localparam logic [6:0] STAT_BASE      = 7'h40;
    localparam int         CLR_NUM        = 6;
    localparam logic [6:0] WAKE_LVL_ADDR  = 7'h46;
    localparam logic [6:0] SELECTIVE_WAKE_STATUS_ADDR  = 7'h47;
    localparam logic [6:0] ERR_CNT_ADDR   = 7'h48;
    localparam logic [6:0] CDR1_ADDR      = 7'h49;
    localparam logic [6:0] CDR2_ADDR      = 7'h4A;
    localparam logic [6:0] FAM_ID_ADDR    = 7'h4B;

    // address search result with no register found
    localparam logic [7:0] ADDR_NONE = 8'h80;
    localparam logic [7:0] ADDR_STEP = 8'h01;

    // frame lengths in clocks
    localparam logic [5:0] LEN16   = 6'h10;
    localparam logic [5:0] LEN32   = 6'h20;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    // fields of mode_and_supply_control, hardware_config_0 and can_transceiver_control
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int SECOND_REGULATOR_HI = 4;
    localparam int SECOND_REGULATOR_LO = 3;
    localparam int FO_BIT  = 5;
    localparam int CAN_HI  = 2;
    localparam int CAN_LO  = 0;

    // device modes, same code in the mode field and on mode_actual
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SLEEP   = 2'h1;
    localparam logic [1:0] MODE_STOP    = 2'h2;
    localparam logic [1:0] MODE_RESTART = 2'h3;
    localparam logic [2:0] CAN_OFF      = 3'h0;
    localparam logic [2:0] CAN_WAKE     = 3'h1;
    localparam logic [1:0] SECOND_REGULATOR_OFF     = 2'h0;

    typedef logic [CTRL_NUM-1:0][7:0] sra_ctrl_t;
    typedef logic [SWK_NUM-1:0][7:0]  sra_swk_t;
    typedef logic [CLR_NUM-1:0][7:0]  sra_stat_t;

    // writable bits per control register, index 14 first
    localparam sra_ctrl_t CTRL_WMASK = {
        8'h07, 8'h03, 8'hFF, 8'h07, 8'hFD, 8'hB8, 8'h7F, 8'h10,
        8'hC3, 8'hA1, 8'h44, 8'h07, 8'hF7, 8'hFF, 8'hDF};
    localparam sra_ctrl_t CTRL_RESET = '0;
    localparam sra_swk_t  SWK_RESET  = '0;
    localparam sra_stat_t STAT_RESET = '0;

    // one spi frame, bit 0 first on the wire
    typedef struct packed {
        logic [7:0] data2;
        logic [7:0] data1;
        logic [7:0] data0;
        logic       write;
        logic [6:0] addr;
    } sra_frame_t;

    // live status bytes that are never cleared
    typedef struct packed {
        logic [7:0] wake_pin_level_status;
        logic [7:0] selective_wake_status;
        logic [7:0] selective_wake_error_count;
        logic [7:0] clock_recovery_status_1;
        logic [7:0] clock_recovery_status_2;
        logic [7:0] osc_calibration_high_status;
        logic [7:0] osc_calibration_low_status;
    } sra_live_t;

endpackage : sra_pkg

// ---- sra_spi_master.sv ----
// spi master model that frames traffic into the register access block
module sra_spi_master (
    // spi link
    output logic      spi_sclk,
    output logic      spi_chip_select_low_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        spi_sclk              = 1'b0;
        spi_chip_select_low_n = 1'b1;
        spi_sdi               = 1'b1;
    end

    // link clock runs only inside a frame; chip select stays low on return
    task automatic shift_bits(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        spi_chip_select_low_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            spi_sdi = tx[i];
            #3;
            rx[i] = spi_sdo;
            spi_sclk = 1'b1;
            #3;
            spi_sclk = 1'b0;
        end
    endtask : shift_bits

    // released data line shows the inverse of its last bit
    task automatic end_frame();
        #3;
        spi_chip_select_low_n = 1'b1;
        spi_sdi = ~spi_sdi;
    endtask : end_frame
endmodule : sra_spi_master

// ---- sra_top.sv ----
// spi register access layer with control, selective wake and status registers
//
// Contract
// [RULE_01] 32-bit frames are accepted only inside the selective wake address range.
// [RULE_02] Oscillator calibration bytes are skipped by 32-bit multi-register access.
// [RULE_03] A reserved address is replaced by the next existing register address.
// [RULE_04] Addresses past the top are ignored and answer zero bytes.
// [RULE_05] Control registers change only when the select bit is one.
// [RULE_06] A written value shows only in the answer of a later frame.
// [RULE_07] Status bytes are returned; clearable bits clear only when select bit is one.
// [RULE_08] Live level, identifier, calibration and wake status bytes never clear.
// [RULE_09] Master should clear flags; drivers stay enableable while flags are set.
// [RULE_10] Every mode transition rewrites the mode field with the actual mode.
// [RULE_11] Low-power entry keeps diagnosis bits and an active fail output.
// [RULE_12] Stop entry leaves the transceiver field untouched.
// [RULE_13] Sleep entry forces the transceiver field unless off or wake capable.
// [RULE_14] Second regulator kept on, set in normal only, switched off on failure.
// [RULE_15] Restart clears regulator bits, keeps fail output, settles transceiver field.
// [RULE_16] Frame holds 7-bit address, select bit, then data byte above.
// [RULE_17] Changes take effect only when chip select returns high.
// [RULE_18] In restart all spi traffic is ignored and registers stay unchanged.
// [RULE_19] In stop only normal-mode change, watchdog writes and status access work.
// [RULE_20] In 32-bit frames every byte uses the select bit and next existing address.
// [RULE_21] Reserved control bits read zero and ignore writes.
module sra_top
    import sra_pkg::*;
#(
    parameter logic [7:0] FAMILY_ID = 8'h5A  // arbitrary identification value
)(
    // system
    input  wire logic  clk,
    input  wire logic  rst_n,
    // spi link
    input  wire logic  spi_sclk,
    input  wire logic  spi_chip_select_low_n,
    input  wire logic  spi_sdi,
    output logic       spi_sdo,
    output logic       spi_sdo_oe,
    // device core
    input  wire logic [1:0] mode_actual,
    input  wire logic  second_regulator_fail,
    input  wire sra_stat_t stat_set,
    input  wire sra_live_t live_stat,
    // register contents
    output sra_ctrl_t  ctrl_regs,
    output sra_swk_t   swk_regs,
    output sra_stat_t  stat_regs
);

    // link domain
    logic [31:0] rx_q;
    logic [5:0]  bit_cnt_q;
    logic        fresh_q;
    logic        frame_tgl_q;
    logic        sdo_q;
    logic [31:0] resp_q;
    wire         link_rst_n;

    assign link_rst_n = rst_n & ~spi_chip_select_low_n;

    // marks the first clock of each frame; set again while chip select is high
    always_ff @(posedge spi_sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            fresh_q <= 1'b1;
        else
            fresh_q <= 1'b0;
    end

    // shift in lsb first; counter and word survive the frame for the clk side
    always_ff @(posedge spi_sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_q        <= '0;
            bit_cnt_q   <= '0;
            frame_tgl_q <= 1'b0;
        end
        else
        begin
            rx_q <= {spi_sdi, rx_q[31:1]};  // [RULE_16]
            if (fresh_q)
            begin
                bit_cnt_q   <= CNT_ONE;
                frame_tgl_q <= ~frame_tgl_q;
            end
            else if (bit_cnt_q != CNT_MAX)
                bit_cnt_q <= bit_cnt_q + CNT_ONE;
        end
    end

    // answer bit k leaves after falling edge k-1; bit 0 is always low
    always_ff @(negedge spi_sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            sdo_q <= 1'b0;
        else
            sdo_q <= (bit_cnt_q < LEN32) ? resp_q[bit_cnt_q[4:0]] : 1'b0;
    end

    assign spi_sdo = sdo_q;

    // clk domain: synchronisers for chip select and the frame toggle
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic tg_s1_q, tg_s2_q, tg_seen_q;
    logic sdo_oe_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            tg_s1_q   <= 1'b0;
            tg_s2_q   <= 1'b0;
            tg_seen_q <= 1'b0;
            sdo_oe_q  <= 1'b0;
        end
        else
        begin
            cs_s1_q   <= spi_chip_select_low_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            tg_s1_q   <= frame_tgl_q;
            tg_s2_q   <= tg_s1_q;
            sdo_oe_q  <= ~cs_s2_q;
            if (cs_s2_q & ~cs_s3_q)
                tg_seen_q <= tg_s2_q;
        end
    end

    assign spi_sdo_oe = sdo_oe_q;

    // frame decode; a frame without clocks leaves the toggle unchanged
    wire        cs_rise   = cs_s2_q & ~cs_s3_q;
    wire        commit    = cs_rise & (tg_s2_q ^ tg_seen_q);  // [RULE_17]
    wire        len16     = bit_cnt_q == LEN16;
    wire        len32     = bit_cnt_q == LEN32;
    wire [31:0] frame_raw = len32 ? rx_q : {16'h0000, rx_q[31:16]};
    sra_frame_t frame;
    assign frame = sra_frame_t'(frame_raw);

    wire in_swk     = (frame.addr >= SWK_BASE) && (frame.addr <= SWK_TOP);
    wire restart    = mode_actual == MODE_RESTART;
    wire low_power  = (mode_actual == MODE_SLEEP) || (mode_actual == MODE_STOP);
    wire accept     = commit & (len16 | (len32 & in_swk)) & ~restart;  // [RULE_01] [RULE_18]
    wire write_sel  = accept & frame.write;  // [RULE_05] [RULE_20]

    function automatic logic exists(input logic [6:0] a, input logic multi);
        logic ctrl_hit, swk_hit, osc_hit, stat_hit;
        ctrl_hit = a < 7'(CTRL_NUM);
        swk_hit  = (a >= SWK_BASE) && (a < SWK_BASE + 7'(SWK_NUM));
        osc_hit  = (a == OSC_CAL_H_ADDR) || (a == OSC_CAL_L_ADDR);
        stat_hit = (a >= STAT_BASE) && (a <= FAM_ID_ADDR);
        if (multi)
            return swk_hit;  // [RULE_02]
        return ctrl_hit | swk_hit | osc_hit | stat_hit;
    endfunction : exists

    // lowest existing address at or above a, or none
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic multi);
        logic [7:0] r;
        r = ADDR_NONE;
        for (int k = 127; k >= 0; k--)
        begin
            if ((8'(k) >= a) && exists(7'(k), multi))
                r = 8'(k);
        end
        return r;  // [RULE_03]
    endfunction : next_addr

    wire [7:0] addr0 = next_addr({1'b0, frame.addr}, len32);  // [RULE_03]
    wire [7:0] addr1 = len32 ? next_addr(addr0 + ADDR_STEP, 1'b1) : ADDR_NONE;  // [RULE_20]
    wire [7:0] addr2 = len32 ? next_addr(addr1 + ADDR_STEP, 1'b1) : ADDR_NONE;  // [RULE_20]

    // register state
    sra_ctrl_t  ctrl_q, ctrl_d;
    sra_swk_t   swk_q, swk_d;
    sra_stat_t  stat_q, stat_d;
    logic [1:0] mode_prev_q;
    logic [31:0] resp_d;

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [6:0] o;
        o = a[6:0];
        if (a[7])
            return 8'h00;  // [RULE_04]
        if (o < 7'(CTRL_NUM))
            return ctrl_q[o[3:0]];
        if ((o >= SWK_BASE) && (o < SWK_BASE + 7'(SWK_NUM)))
            return swk_q[3'(o - SWK_BASE)];
        if (o == OSC_CAL_H_ADDR)
            return live_stat.osc_calibration_high_status;
        if (o == OSC_CAL_L_ADDR)
            return live_stat.osc_calibration_low_status;
        if ((o >= STAT_BASE) && (o < STAT_BASE + 7'(CLR_NUM)))
            return stat_q[3'(o - STAT_BASE)];
        case (o)  // [RULE_08]
            WAKE_LVL_ADDR: return live_stat.wake_pin_level_status;
            SELECTIVE_WAKE_STATUS_ADDR: return live_stat.selective_wake_status;
            ERR_CNT_ADDR:  return live_stat.selective_wake_error_count;
            CDR1_ADDR:     return live_stat.clock_recovery_status_1;
            CDR2_ADDR:     return live_stat.clock_recovery_status_2;
            FAM_ID_ADDR:   return FAMILY_ID;
            default:       return 8'h00;
        endcase
    endfunction : rd_byte

    // answer built from the contents before this frame acts
    assign resp_d = accept ? {rd_byte(addr2), rd_byte(addr1), rd_byte(addr0), frame.write, 7'h00}
                           : 32'h0000_0000;  // [RULE_06] [RULE_04]

    // per control register write, masked by its writable bits
    sra_ctrl_t ctrl_wr;
    genvar gi;
    generate
        for (gi = 0; gi < CTRL_NUM; gi++)
        begin : g_ctrl
            wire hit     = write_sel && (addr0 == 8'(gi));
            wire allowed = ~low_power || (7'(gi) == WATCHDOG_CONTROL);  // [RULE_19]
            assign ctrl_wr[gi] = (hit && allowed)
                ? ((ctrl_q[gi] & ~CTRL_WMASK[gi]) | (frame.data0 & CTRL_WMASK[gi]))  // [RULE_21]
                : ctrl_q[gi];
        end
    endgenerate

    wire       mode_change = mode_actual != mode_prev_q;
    wire       msc_hit     = write_sel && (addr0[6:0] == MODE_AND_SUPPLY_CONTROL) && ~addr0[7];
    wire [2:0] can_now     = ctrl_q[CAN_TRANSCEIVER_CONTROL][CAN_HI:CAN_LO];
    wire       can_fixed   = (can_now == CAN_OFF) || (can_now == CAN_WAKE);

    // mode field, regulator and transceiver updates on top of the write
    always_comb
    begin
        ctrl_d = ctrl_wr;
        if (msc_hit && low_power)
        begin
            if (frame.data0[MODE_HI:MODE_LO] == MODE_NORMAL)
                ctrl_d[MODE_AND_SUPPLY_CONTROL][MODE_HI:MODE_LO] = MODE_NORMAL;  // [RULE_19]
        end
        if (mode_change)
        begin
            ctrl_d[MODE_AND_SUPPLY_CONTROL][MODE_HI:MODE_LO] = mode_actual;  // [RULE_10]
            if (((mode_actual == MODE_SLEEP) || restart) && !can_fixed)
                ctrl_d[CAN_TRANSCEIVER_CONTROL][CAN_HI:CAN_LO] = CAN_WAKE;  // [RULE_13] [RULE_15] [RULE_12]
            if (restart)
                ctrl_d[MODE_AND_SUPPLY_CONTROL][SECOND_REGULATOR_HI:SECOND_REGULATOR_LO] = SECOND_REGULATOR_OFF;  // [RULE_15]
        end
        if (second_regulator_fail)
            ctrl_d[MODE_AND_SUPPLY_CONTROL][SECOND_REGULATOR_HI:SECOND_REGULATOR_LO] = SECOND_REGULATOR_OFF;  // [RULE_14]
    end

    // selective wake bytes: up to three written by one frame
    generate
        for (gi = 0; gi < SWK_NUM; gi++)
        begin : g_swk
            wire [7:0] me = 8'(SWK_BASE) + 8'(gi);
            wire       ok = write_sel && ~low_power;  // [RULE_19]
            assign swk_d[gi] = (ok && addr0 == me) ? frame.data0 :
                               (ok && addr1 == me) ? frame.data1 :  // [RULE_20]
                               (ok && addr2 == me) ? frame.data2 : swk_q[gi];
        end
    endgenerate

    // clearable status bytes; a new event wins over a clear in the same cycle
    generate
        for (gi = 0; gi < CLR_NUM; gi++)
        begin : g_stat
            wire clr = write_sel && (addr0 == 8'(STAT_BASE) + 8'(gi));  // [RULE_07]
            assign stat_d[gi] = (clr ? 8'h00 : stat_q[gi]) | stat_set[gi];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q      <= CTRL_RESET;
            swk_q       <= SWK_RESET;
            stat_q      <= STAT_RESET;
            mode_prev_q <= MODE_NORMAL;
            resp_q      <= '0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            swk_q       <= swk_d;
            stat_q      <= stat_d;
            mode_prev_q <= mode_actual;
            if (commit)
                resp_q <= resp_d;
        end
    end

    assign ctrl_regs = ctrl_q;
    assign swk_regs  = swk_q;
    assign stat_regs = stat_q;

    // checks
    mode_follow_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_10]
        mode_change |=> ctrl_q[MODE_AND_SUPPLY_CONTROL][MODE_HI:MODE_LO] == $past(mode_actual))
        else $error("mode field does not follow actual mode");

    restart_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_18]
        (restart && !mode_change && !second_regulator_fail) |=> $stable(swk_q) && $stable(ctrl_q))
        else $error("register changed in restart");

    stop_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_19]
        (write_sel && low_power && !mode_change && addr0 == 8'(HARDWARE_CONFIG_0))
        |=> $stable(ctrl_q[HARDWARE_CONFIG_0]))
        else $error("control write accepted in low power");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_21]
        (ctrl_q[CAN_TRANSCEIVER_CONTROL] & ~CTRL_WMASK[CAN_TRANSCEIVER_CONTROL]) == 8'h00)
        else $error("reserved control bit set");

    sleep_can_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_13]
        (mode_change && mode_actual == MODE_SLEEP && !can_fixed)
        |=> ctrl_q[CAN_TRANSCEIVER_CONTROL][CAN_HI:CAN_LO] == CAN_WAKE)
        else $error("transceiver field not forced on sleep entry");

    stop_can_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_12]
        (mode_change && mode_actual == MODE_STOP && !commit)
        |=> $stable(ctrl_q[CAN_TRANSCEIVER_CONTROL]))
        else $error("transceiver field changed on stop entry");

    fail_keep_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_11]
        (mode_change && !commit) |=> $stable(ctrl_q[HARDWARE_CONFIG_0][FO_BIT]))
        else $error("fail output changed on mode change");

    reg_fail_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_14]
        second_regulator_fail |=> ctrl_q[MODE_AND_SUPPLY_CONTROL][SECOND_REGULATOR_HI:SECOND_REGULATOR_LO] == SECOND_REGULATOR_OFF)
        else $error("regulator bits not cleared on failure");

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_07]
        (stat_set[1] != 8'h00) |=> ((stat_q[1] & $past(stat_set[1])) == $past(stat_set[1])))
        else $error("status event lost");

    commit_only_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_17]
        (!commit && !mode_change && !second_regulator_fail) |=> $stable(swk_q) && $stable(ctrl_q))
        else $error("register changed outside frame end");

    long_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_01]
        (commit && len32 && !in_swk && !mode_change && !second_regulator_fail)
        |=> (resp_q == 32'h0000_0000) && $stable(swk_q) && $stable(ctrl_q))
        else $error("long frame outside wake range accepted");

    osc_skip_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_02]
        (accept && len32) |-> (addr0[6:0] != OSC_CAL_H_ADDR) && (addr0[6:0] != OSC_CAL_L_ADDR)
            && (addr1[6:0] != OSC_CAL_H_ADDR) && (addr1[6:0] != OSC_CAL_L_ADDR))
        else $error("calibration byte reached by long frame");

    reserved_skip_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_03]
        (accept && len16 && (frame.addr > HARDWARE_CONFIG_3) && (frame.addr < SWK_BASE))
        |-> addr0 == 8'(SWK_BASE))
        else $error("reserved address not moved to next register");

    top_zero_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_04]
        (accept && addr0[7]) |=> resp_q[15:8] == 8'h00)
        else $error("address past the top answered non-zero");

    read_keep_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_05]
        (accept && !frame.write && !mode_change && !second_regulator_fail)
        |=> $stable(ctrl_q) && $stable(swk_q))
        else $error("read-only frame changed a register");

    status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_07]
        (write_sel && (addr0 == 8'(STAT_BASE) + ADDR_STEP) && (stat_set[1] == 8'h00))
        |=> stat_q[1] == 8'h00)
        else $error("status byte not cleared");

    restart_reg_a: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_15]
        (mode_change && restart) |=> ctrl_q[MODE_AND_SUPPLY_CONTROL][SECOND_REGULATOR_HI:SECOND_REGULATOR_LO] == SECOND_REGULATOR_OFF)
        else $error("regulator bits kept in restart");

endmodule : sra_top

// ---- sra_top_bench.sv ----
// self-checking bench for the spi register access block
module sra_top_bench
    import sra_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, rst_n, sclk, chip_select_low, sdi, sdo, sdo_oe, reg_fail;
    logic [1:0] mode_actual;
    sra_stat_t  stat_set, stat_regs;
    sra_live_t  live_stat;
    sra_ctrl_t  ctrl_regs;
    sra_swk_t   swk_regs;
    logic [31:0] rsp;
    int         miscompares, checked;

    sra_top u_dut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_chip_select_low_n(chip_select_low), .spi_sdi(sdi),
        .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .mode_actual(mode_actual), .second_regulator_fail(reg_fail),
        .stat_set(stat_set), .live_stat(live_stat), .ctrl_regs(ctrl_regs), .swk_regs(swk_regs),
        .stat_regs(stat_regs));
    sra_spi_master u_master (.spi_sclk(sclk), .spi_chip_select_low_n(chip_select_low), .spi_sdi(sdi), .spi_sdo(sdo));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic xfer(input logic sel, input logic [6:0] addr, input logic [23:0] data, input int nbits);
        u_master.shift_bits({data, sel, addr}, nbits, rsp);
        u_master.end_frame();
        repeat (6) @(posedge clk);
    endtask : xfer

    // answer word of the previous frame
    task automatic expect_rsp(input logic sel, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        check("rsp head", rsp[7:0], {sel, 7'h00});
        check("rsp byte0", rsp[15:8], b0);
        check("rsp byte1", rsp[23:16], b1);
        check("rsp byte2", rsp[31:24], b2);
    endtask : expect_rsp

    task automatic set_mode(input logic [1:0] m);
        @(posedge clk) mode_actual <= m;
        repeat (3) @(posedge clk);
    endtask : set_mode

    task automatic t_write_read();
        u_master.shift_bits({16'h0000, 8'hFF, 1'b1, WATCHDOG_CONTROL}, 16, rsp);
        repeat (4) @(posedge clk);
        check("held until cs rise", ctrl_regs[2], 8'h00);
        check("oe driving", {7'h00, sdo_oe}, 8'h01);
        u_master.end_frame();
        repeat (6) @(posedge clk);
        xfer(1'b0, WATCHDOG_CONTROL, 24'h0000AA, 16);
        expect_rsp(1'b1, 8'h00, 8'h00, 8'h00);
        check("read leaves reg", ctrl_regs[2], 8'hFF & CTRL_WMASK[2]);
        xfer(1'b0, 7'h7F, 24'h0, 16);
        expect_rsp(1'b0, 8'hFF & CTRL_WMASK[2], 8'h00, 8'h00);
    endtask : t_write_read

    task automatic t_burst();
        xfer(1'b1, 7'h0F, 24'h0000A5, 16);
        check("reserved skip", swk_regs[0], 8'hA5);
        xfer(1'b1, 7'h26, 24'h332211, 32);
        check("burst byte0", swk_regs[6], 8'h11);
        check("burst byte1", swk_regs[7], 8'h22);
        xfer(1'b0, 7'h26, 24'h0, 32);
        xfer(1'b0, OSC_CAL_H_ADDR, 24'h0, 32);
        expect_rsp(1'b0, 8'h11, 8'h22, 8'h00);
        xfer(1'b1, WATCHDOG_CONTROL, 24'h0, 32);
        expect_rsp(1'b0, 8'h00, 8'h00, 8'h00);
        check("long frame refused", ctrl_regs[2], 8'hFF & CTRL_WMASK[2]);
    endtask : t_burst

    task automatic t_status();
        @(posedge clk) stat_set[1] <= 8'h0F;
        @(posedge clk) stat_set[1] <= 8'h00;
        repeat (2) @(posedge clk);
        xfer(1'b0, 7'h41, 24'h0, 16);
        check("read only keeps", stat_regs[1], 8'h0F);
        xfer(1'b1, GENERAL_PIN_CONFIG, 24'h05, 16);
        check("write with flag set", ctrl_regs[11], 8'h05 & CTRL_WMASK[11]);
        xfer(1'b1, 7'h41, 24'h0, 16);
        check("clear", stat_regs[1], 8'h00);
        xfer(1'b1, WAKE_LVL_ADDR, 24'h0, 16);
        expect_rsp(1'b1, 8'h0F, 8'h00, 8'h00);
        xfer(1'b0, 7'h7F, 24'h0, 16);
        expect_rsp(1'b1, 8'h3C, 8'h00, 8'h00);
    endtask : t_status

    task automatic t_modes();
        xfer(1'b1, CAN_TRANSCEIVER_CONTROL, 24'h03, 16);
        xfer(1'b1, HARDWARE_CONFIG_0, 24'h20, 16);
        xfer(1'b1, MODE_AND_SUPPLY_CONTROL, 24'h18, 16);
        set_mode(MODE_STOP);
        check("mode stop", {6'h00, ctrl_regs[0][7:6]}, {6'h00, MODE_STOP});
        check("can kept", ctrl_regs[3], 8'h03);
        check("reg kept", {6'h00, ctrl_regs[0][4:3]}, 8'h03);
        xfer(1'b1, HARDWARE_CONFIG_0, 24'h00, 16);
        check("stop write refused", ctrl_regs[1], 8'h20);
        xfer(1'b1, WATCHDOG_CONTROL, 24'h01, 16);
        check("stop watchdog", ctrl_regs[2], 8'h01 & CTRL_WMASK[2]);
        set_mode(MODE_SLEEP);
        check("can forced", {5'h00, ctrl_regs[3][2:0]}, {5'h00, CAN_WAKE});
        check("fail out kept", {7'h00, ctrl_regs[1][5]}, 8'h01);
        set_mode(MODE_NORMAL);
        check("mode normal", {6'h00, ctrl_regs[0][7:6]}, {6'h00, MODE_NORMAL});
        @(posedge clk) reg_fail <= 1'b1;
        @(posedge clk) reg_fail <= 1'b0;
        repeat (2) @(posedge clk);
        check("reg fail off", {6'h00, ctrl_regs[0][4:3]}, {6'h00, SECOND_REGULATOR_OFF});
        xfer(1'b1, MODE_AND_SUPPLY_CONTROL, 24'h18, 16);
        set_mode(MODE_RESTART);
        check("restart reg", {6'h00, ctrl_regs[0][4:3]}, {6'h00, SECOND_REGULATOR_OFF});
        check("restart fail out", {7'h00, ctrl_regs[1][5]}, 8'h01);
        xfer(1'b1, WATCHDOG_CONTROL, 24'h07, 16);
        check("restart ignores", ctrl_regs[2], 8'h01 & CTRL_WMASK[2]);
        set_mode(MODE_NORMAL);
    endtask : t_modes

    initial
    begin
        #200us;
        miscompares++;
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        mode_actual = MODE_NORMAL;
        reg_fail = 1'b0;
        stat_set = '0;
        live_stat = '0;
        live_stat.wake_pin_level_status = 8'h3C;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("oe idle", {7'h00, sdo_oe}, 8'h00);
        check("reset ctrl", ctrl_regs[2], 8'h00);
        xfer(1'b0, 7'h7F, 24'h0, 16);
        expect_rsp(1'b0, 8'h00, 8'h00, 8'h00);
        t_write_read();
        t_burst();
        t_status();
        t_modes();
        complete_run();
    end
endmodule : sra_top_bench
